// ==== ntsr_regs.sv ====
// module: wishbone slave for tx count, status view and antenna tuning registers
`timescale 1ns/1ps
module ntsr_regs
  import ntsr_pkg::*;
(
  // clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  // wishbone slave
  input  wire logic           cyc_i,
  input  wire logic           stb_i,
  input  wire logic           we_i,
  input  wire logic [7:0]     adr_i,
  input  wire logic [3:0]     sel_i,
  input  wire logic [31:0]    dat_i,
  output logic      [31:0]    dat_o,
  output logic                ack_o,
  // device status inputs
  input  wire logic [3:0]     pt_state_i,
  input  wire ntsr_rate_tmr_t rate_tmr_i,
  input  wire logic [7:0]     conv_data_i,
  input  wire logic           conv_done_i,
  // transmit context
  input  wire logic           anticoll_i,
  input  wire logic           passive_target_i,
  input  wire logic           req_wake_cmd_i,
  // transmit control outputs
  output ntsr_tx_count_t      tx_count_o,
  output logic [7:0]          tail_mask_o,
  output logic                no_parity_o,
  output logic                nibble_reply_o,
  output logic                par_err_o,
  // tuning converter codes
  output logic [7:0]          tune_a_o,
  output logic [7:0]          tune_b_o
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [7:0] low_mask(input logic [2:0] n);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(n)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // ****************************************
  // bus decode
  // ****************************************
  logic       req;
  logic       wr_lane;
  logic [5:0] idx;

  assign req     = cyc_i && stb_i && !ack_o;
  assign wr_lane = req && we_i && sel_i[0];
  assign idx     = adr_i[7:2];

  // ****************************************
  // register state
  // ****************************************
  logic [7:0]     cnt_high;
  logic [7:0]     cnt_low;
  logic [7:0]     tune_a;
  logic [7:0]     tune_b;
  logic [3:0]     pt_view;
  ntsr_rate_tmr_t rt_view;
  logic [7:0]     conv_view;
  logic [7:0]     next_cnt_high;
  logic [7:0]     next_cnt_low;
  logic [7:0]     next_tune_a;
  logic [7:0]     next_tune_b;
  logic [3:0]     next_pt_view;
  ntsr_rate_tmr_t next_rt_view;
  logic [7:0]     next_conv_view;

  always_comb begin
    next_cnt_high  = cnt_high;
    next_cnt_low   = cnt_low;
    next_tune_a    = tune_a;
    next_tune_b    = tune_b;
    next_pt_view   = pt_state_i;                            // [RQ1]
    next_rt_view   = rate_tmr_i;                            // [RQ11] [RQ12]
    next_conv_view = conv_view;
    if (conv_done_i) begin
      next_conv_view = conv_data_i;                         // [RQ13]
    end
    if (wr_lane) begin
      unique case (idx)
        IDX_CNT_HIGH: next_cnt_high = dat_i[7:0];           // [RQ3] [RQ17]
        IDX_CNT_LOW:  next_cnt_low  = dat_i[7:0];           // [RQ3] [RQ5] [RQ17]
        IDX_TUNE_A:   next_tune_a   = dat_i[7:0];           // [RQ14]
        IDX_TUNE_B:   next_tune_b   = dat_i[7:0];           // [RQ15]
        default: begin
          next_cnt_high = cnt_high;                         // [RQ16]
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_high  <= ZERO_RST;
      cnt_low   <= ZERO_RST;
      tune_a    <= TUNE_RST;
      tune_b    <= TUNE_RST;
      pt_view   <= PT_POWER_OFF;
      rt_view   <= '0;
      conv_view <= ZERO_RST;
    end else begin
      cnt_high  <= next_cnt_high;
      cnt_low   <= next_cnt_low;
      tune_a    <= next_tune_a;
      tune_b    <= next_tune_b;
      pt_view   <= next_pt_view;
      rt_view   <= next_rt_view;
      conv_view <= next_conv_view;
    end
  end

  // ****************************************
  // bus answer
  // ****************************************
  logic [31:0] next_dat;
  logic        next_ack;

  always_comb begin
    next_ack = req;
    next_dat = 32'h0000_0000;
    if (req && !we_i) begin
      unique case (idx)
        IDX_PT_STATE: next_dat = {28'h000_0000, pt_view};   // [RQ1] [RQ16]
        IDX_CNT_HIGH: next_dat = {24'h00_0000, cnt_high};
        IDX_CNT_LOW:  next_dat = {24'h00_0000, cnt_low};
        IDX_RATE_TMR: next_dat = {26'h00_0000, rt_view};    // [RQ11] [RQ12] [RQ16]
        IDX_CONV:     next_dat = {24'h00_0000, conv_view};  // [RQ13]
        IDX_TUNE_A:   next_dat = {24'h00_0000, tune_a};
        IDX_TUNE_B:   next_dat = {24'h00_0000, tune_b};
        default:      next_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end

  // ****************************************
  // transmit control
  // ****************************************
  ntsr_tx_count_t next_tx_count;
  logic [7:0]     next_tail_mask;
  logic           next_no_parity;
  logic           next_nibble;
  logic           next_par_err;

  always_comb begin
    next_tx_count.full_bytes = {next_cnt_high, next_cnt_low[7:3]};   // [RQ3]
    next_tx_count.extra_bits = next_cnt_low[2:0];                    // [RQ5]
    next_tail_mask = low_mask(next_cnt_low[2:0]);                    // [RQ6]
    next_no_parity = anticoll_i && (next_cnt_low[2:0] != 3'h0);      // [RQ7]
    next_nibble    = passive_target_i
                     && (next_cnt_low[2:0] == NIBBLE_BITS);          // [RQ8]
    next_par_err   = anticoll_i && req_wake_cmd_i && (pt_view == PT_IDLE)
                     && (cnt_low[2:0] != 3'h0);                      // [RQ9]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_count_o     <= '0;
      tail_mask_o    <= 8'h00;
      no_parity_o    <= 1'b0;
      nibble_reply_o <= 1'b0;
      par_err_o      <= 1'b0;
      tune_a_o       <= TUNE_RST;
      tune_b_o       <= TUNE_RST;
    end else begin
      tx_count_o     <= next_tx_count;
      tail_mask_o    <= next_tail_mask;
      no_parity_o    <= next_no_parity;
      nibble_reply_o <= next_nibble;
      par_err_o      <= next_par_err;
      tune_a_o       <= next_tune_a;                                 // [RQ14]
      tune_b_o       <= next_tune_b;                                 // [RQ15]
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_ack_single_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  chk_ack_latency: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not answered in one cycle");

  chk_tune_a_write: assert property ( // [RQ14]
    @(posedge clk_i) disable iff (rst_i)
    (wr_lane && idx == IDX_TUNE_A) |=> (tune_a_o == $past(dat_i[7:0])))
    else $error("first tuning code not forwarded");

  chk_tune_b_write: assert property ( // [RQ15]
    @(posedge clk_i) disable iff (rst_i)
    (wr_lane && idx == IDX_TUNE_B) |=> (tune_b_o == $past(dat_i[7:0])))
    else $error("second tuning code not forwarded");

  chk_count_hold: assert property ( // [RQ17]
    @(posedge clk_i) disable iff (rst_i)
    !(wr_lane && (idx == IDX_CNT_HIGH || idx == IDX_CNT_LOW)) ##1
    !(wr_lane && (idx == IDX_CNT_HIGH || idx == IDX_CNT_LOW))
    |=> $stable(tx_count_o))
    else $error("tx count changed without a write");

  chk_par_err_raise: assert property ( // [RQ9]
    @(posedge clk_i) disable iff (rst_i)
    (anticoll_i && req_wake_cmd_i && pt_view == PT_IDLE && cnt_low[2:0] != 3'h0)
    |=> par_err_o)
    else $error("parity error not raised");

  chk_ro_read_zero: assert property ( // [RQ16]
    @(posedge clk_i) disable iff (rst_i)
    (req && !we_i && idx == IDX_PT_STATE) |=> (dat_o[31:4] == 28'h000_0000)
    && (dat_o[3:0] == $past(pt_view)))
    else $error("state view read wrong");

  chk_no_parity_flag: assert property ( // [RQ7]
    @(posedge clk_i) disable iff (rst_i)
    no_parity_o |-> (tx_count_o.extra_bits != 3'h0))
    else $error("parity suppressed on whole bytes");

  chk_tail_mask_lsb: assert property ( // [RQ6]
    @(posedge clk_i) disable iff (rst_i)
    (tx_count_o.extra_bits != 3'h0) |-> tail_mask_o[0]
    && ($countones(tail_mask_o) == int'(tx_count_o.extra_bits)))
    else $error("tail bits not taken from the lsb");

  chk_count_split: assert property ( // [RQ3]
    @(posedge clk_i) disable iff (rst_i)
    (wr_lane && idx == IDX_CNT_HIGH) |=> (tx_count_o.full_bytes[12:5] == $past(dat_i[7:0])))
    else $error("full byte count split wrong");

  chk_count_low_split: assert property ( // [RQ3] [RQ5]
    @(posedge clk_i) disable iff (rst_i)
    (wr_lane && idx == IDX_CNT_LOW) |=> (tx_count_o.full_bytes[4:0] == $past(dat_i[7:3]))
    && (tx_count_o.extra_bits == $past(dat_i[2:0])))
    else $error("low count byte split wrong");

  chk_par_err_quiet: assert property ( // [RQ9]
    @(posedge clk_i) disable iff (rst_i)
    !(anticoll_i && req_wake_cmd_i && pt_view == PT_IDLE && cnt_low[2:0] != 3'h0)
    |=> !par_err_o)
    else $error("parity error raised without cause");

  chk_no_parity_set: assert property ( // [RQ7]
    @(posedge clk_i) disable iff (rst_i)
    (anticoll_i && !wr_lane && cnt_low[2:0] != 3'h0) |=> no_parity_o)
    else $error("parity kept on a split last byte");

  chk_nibble_set: assert property ( // [RQ8]
    @(posedge clk_i) disable iff (rst_i)
    (passive_target_i && !wr_lane && cnt_low[2:0] == NIBBLE_BITS) |=> nibble_reply_o)
    else $error("nibble reply not flagged");

  chk_conv_capture: assert property ( // [RQ13]
    @(posedge clk_i) disable iff (rst_i)
    conv_done_i |=> (conv_view == $past(conv_data_i)))
    else $error("conversion result not captured");

  chk_conv_hold: assert property ( // [RQ13] [RQ16]
    @(posedge clk_i) disable iff (rst_i)
    !conv_done_i |=> $stable(conv_view))
    else $error("conversion result changed without a strobe");

  chk_state_follow: assert property ( // [RQ1]
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (pt_view == $past(pt_state_i)))
    else $error("state view lost the input code");

  chk_rate_follow: assert property ( // [RQ11] [RQ12]
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (rt_view == $past(rate_tmr_i)))
    else $error("rate and timer view lost the inputs");

  chk_tail_mask_zero: assert property ( // [RQ5]
    @(posedge clk_i) disable iff (rst_i)
    (tx_count_o.extra_bits == 3'h0) |-> (tail_mask_o == 8'h00))
    else $error("tail bits sent on whole bytes");

  chk_tune_a_hold: assert property ( // [RQ14]
    @(posedge clk_i) disable iff (rst_i)
    !(wr_lane && idx == IDX_TUNE_A) |=> $stable(tune_a_o))
    else $error("first tuning code changed without a write");

  chk_tune_b_hold: assert property ( // [RQ15]
    @(posedge clk_i) disable iff (rst_i)
    !(wr_lane && idx == IDX_TUNE_B) |=> $stable(tune_b_o))
    else $error("second tuning code changed without a write");

endmodule

// ==== ntsr_pkg.sv ====
// package: register map, field layout and status carriers of the tx status and tuning bank
// Summary of operation
// RQ1: The passive target state is shown as a 4-bit code in bits 3:0 with the reserved codes unused.
// RQ2: In active or starred active state the host itself handles every received command.
// RQ3: A 13-bit full byte count is held with its top eight bits at 22h and low five at 23h[7:3].
// RQ4: The host never programs a full byte count above 8191.
// RQ5: Bits 2:0 of 23h give the extra bits sent after the last full byte, zero meaning none.
// RQ6: The bits of a trailing partial byte are sent least significant bit first.
// RQ7: A split-byte type-A anticollision frame is sent without parity generation.
// RQ8: In passive target operation the trailing bit count allows 4-bit ack and nack replies.
// RQ9: Anticollision set, card idle and a nonzero bit count raise parity error on request or wake-up.
// RQ10: The host sends short frames only for type A or B through transmit without CRC.
// RQ11: The bit-rate detection result sits in bits 5:4 of the read-only register at 24h.
// RQ12: Bits 3:0 of 24h are live running flags of the guard, general, no-response and mask timers.
// RQ13: The last conversion result is readable at 25h.
// RQ14: Register 26h drives the first tuning converter code and resets to 80h.
// RQ15: Register 27h drives the second tuning converter code and resets to 80h.
// RQ16: Writes to read-only registers are ignored and reserved bits read as zero.
// RQ17: The byte and bit count registers hold until rewritten or reset.
package ntsr_pkg;
  // ****************************************
  // register indices, byte address is index times four
  // ****************************************
  localparam logic [5:0] IDX_PT_STATE  = 6'h21;
  localparam logic [5:0] IDX_CNT_HIGH  = 6'h22;
  localparam logic [5:0] IDX_CNT_LOW   = 6'h23;
  localparam logic [5:0] IDX_RATE_TMR  = 6'h24;
  localparam logic [5:0] IDX_CONV      = 6'h25;
  localparam logic [5:0] IDX_TUNE_A    = 6'h26;
  localparam logic [5:0] IDX_TUNE_B    = 6'h27;
  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [7:0] TUNE_RST      = 8'h80;
  localparam logic [7:0] ZERO_RST      = 8'h00;
  localparam logic [3:0] PT_POWER_OFF  = 4'h0;
  localparam logic [3:0] PT_IDLE       = 4'h1;
  localparam logic [3:0] PT_ACTIVE     = 4'h5;
  localparam logic [3:0] PT_ACTIVE_S   = 4'hD;
  localparam logic [2:0] NIBBLE_BITS   = 3'h4;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [1:0] bit_rate;
    logic       guard_timer2_running;
    logic       gp_timer_running;
    logic       no_resp_timer_running;
    logic       mask_rx_timer_running;
  } ntsr_rate_tmr_t;
  typedef struct packed {
    logic [12:0] full_bytes;
    logic [2:0]  extra_bits;
  } ntsr_tx_count_t;
endpackage

// ==== ntsr_host.sv ====
// host model driving the wishbone port of the bank
`timescale 1ns/1ps
module ntsr_host (
  // clock
  input  wire logic        clk_i,
  // wishbone master
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i
);
  // ****************
  // classic cycle, one register byte
  // ****************
  // counts fit 13 bits by width
  // commands and short frames stay host code
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  task automatic xfer(input logic w, input logic [5:0] x, input logic [7:0] d,
                      output logic [31:0] q, output logic ok);
    ok = 1'b0;
    q = 32'h0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= {x, 2'h0};
    sel_o <= 4'h1;
    dat_o <= {24'h0, d};
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) begin
        ok = 1'b1;
        q = dat_i;
      end
    end
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  endtask
endmodule

// ==== ntsr_regs_tb.sv ====
// self-checking bench of the tx status and tuning bank
`timescale 1ns/1ps
module ntsr_regs_tb;
  import ntsr_pkg::*;
  logic           clk_i, rst_i, cyc, stb, we, ack;
  logic [7:0]     adr, conv_data_i, tail_mask_o, tune_a_o, tune_b_o;
  logic [3:0]     sel, pt_state_i;
  logic [31:0]    wdat, rdat;
  ntsr_rate_tmr_t rate_tmr_i;
  ntsr_tx_count_t tx_count_o;
  logic           conv_done_i, anticoll_i, passive_target_i, req_wake_cmd_i;
  logic           no_parity_o, nibble_reply_o, par_err_o;
  int             num_errors = 0;
  int             comparisons = 0;
  ntsr_regs ntsr_regs_i (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .pt_state_i, .rate_tmr_i, .conv_data_i, .conv_done_i, .anticoll_i,
    .passive_target_i, .req_wake_cmd_i, .tx_count_o, .tail_mask_o,
    .no_parity_o, .nibble_reply_o, .par_err_o, .tune_a_o, .tune_b_o);
  ntsr_host ntsr_host_i (.clk_i, .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
  // ****************
  // helpers
  // ****************
  task automatic final_report;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] x, input logic [7:0] d,
                     input logic [31:0] exp);
    logic [31:0] q;
    logic        ok;
    ntsr_host_i.xfer(w, x, d, q, ok);
    if (ok !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t ack %h exp %h", $time, ok, 1'b1);
      final_report;
    end
    chk(q, exp);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    chk(tx_count_o, 32'h0);
    chk(tune_a_o, 32'h80);
    chk(tune_b_o, 32'h80);
    bus(1'b0, IDX_CNT_LOW, 8'h00, 32'h0);
    bus(1'b0, IDX_TUNE_A, 8'h00, 32'h80);
  endtask
  task automatic t_count;
    bus(1'b1, IDX_CNT_HIGH, 8'hFF, 32'h0);
    bus(1'b1, IDX_CNT_LOW, 8'hFD, 32'h0);
    chk(tx_count_o, {13'h1FFF, 3'h5});
    chk(tail_mask_o, 32'h1F);
    repeat (20) @(posedge clk_i);
    bus(1'b0, IDX_CNT_HIGH, 8'h00, 32'hFF);
    bus(1'b0, IDX_CNT_LOW, 8'h00, 32'hFD);
    bus(1'b1, IDX_CNT_HIGH, 8'h01, 32'h0);
    bus(1'b1, IDX_CNT_LOW, 8'h20, 32'h0);
    chk(tx_count_o, {13'h0024, 3'h0});
    chk(tail_mask_o, 32'h0);
  endtask
  task automatic t_flags;
    bus(1'b1, IDX_CNT_LOW, 8'h04, 32'h0);
    chk(no_parity_o, 32'h0);
    @(posedge clk_i);
    anticoll_i <= 1'b1;
    passive_target_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(no_parity_o, 32'h1);
    chk(nibble_reply_o, 32'h1);
    chk(tail_mask_o, 32'h0F);
    bus(1'b1, IDX_CNT_LOW, 8'h03, 32'h0);
    chk(nibble_reply_o, 32'h0);
    bus(1'b1, IDX_CNT_LOW, 8'h04, 32'h0);
  endtask
  task automatic t_par(input logic [3:0] s, input logic [2:0] b, input int exp);
    int n = 0;
    bus(1'b1, IDX_CNT_LOW, {5'h00, b}, 32'h0);
    @(posedge clk_i);
    pt_state_i <= s;
    repeat (2) @(posedge clk_i);
    req_wake_cmd_i <= 1'b1;
    @(posedge clk_i);
    req_wake_cmd_i <= 1'b0;
    repeat (4) begin
      @(posedge clk_i);
      if (par_err_o === 1'b1) n++;
    end
    chk(n, exp);
  endtask
  task automatic t_status;
    logic [3:0] c [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h9, 4'hA, 4'hB, 4'hD};
    foreach (c[i]) begin
      @(posedge clk_i);
      pt_state_i <= c[i];
      repeat (2) @(posedge clk_i);
      bus(1'b0, IDX_PT_STATE, 8'h00, {28'h0, c[i]});
    end
    @(posedge clk_i);
    rate_tmr_i <= 6'h2A;
    repeat (2) @(posedge clk_i);
    bus(1'b0, IDX_RATE_TMR, 8'h00, 32'h2A);
    rate_tmr_i <= 6'h15;
    conv_data_i <= 8'hC3;
    conv_done_i <= 1'b1;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
    conv_data_i <= 8'h5A;
    repeat (2) @(posedge clk_i);
    bus(1'b0, IDX_CONV, 8'h00, 32'hC3);
    bus(1'b0, IDX_RATE_TMR, 8'h00, 32'h15);
  endtask
  task automatic t_ro_tune;
    bus(1'b1, IDX_CONV, 8'hFF, 32'h0);
    bus(1'b1, IDX_RATE_TMR, 8'hFF, 32'h0);
    bus(1'b1, IDX_PT_STATE, 8'hFF, 32'h0);
    bus(1'b0, IDX_PT_STATE, 8'h00, 32'hD);
    bus(1'b0, IDX_CONV, 8'h00, 32'hC3);
    bus(1'b0, IDX_RATE_TMR, 8'h00, 32'h15);
    bus(1'b1, 6'h30, 8'h77, 32'h0);
    bus(1'b0, 6'h30, 8'h00, 32'h0);
    bus(1'b1, IDX_TUNE_A, 8'h55, 32'h0);
    bus(1'b1, IDX_TUNE_B, 8'hAA, 32'h0);
    chk(tune_a_o, 32'h55);
    chk(tune_b_o, 32'hAA);
    bus(1'b0, IDX_TUNE_B, 8'h00, 32'hAA);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    pt_state_i = 4'h0;
    rate_tmr_i = 6'h00;
    conv_data_i = 8'h00;
    conv_done_i = 1'b0;
    anticoll_i = 1'b0;
    passive_target_i = 1'b0;
    req_wake_cmd_i = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_count;
    t_flags;
    t_par(PT_IDLE, 3'h4, 1);
    t_par(PT_ACTIVE, 3'h4, 0);
    t_par(PT_IDLE, 3'h0, 0);
    t_status;
    t_ro_tune;
    final_report;
  end
endmodule
